// *** ash_handler.sv ***
// Adapter setup command handler: command port, replies, timers and bus request
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ps
module ash_handler
	import ash_pkg::*;
#(
	parameter int CYC_PER_MS = MS_NS / CLK_PERIOD_NS,
	parameter logic [7:0] BOARD_TYPE = 8'h5A, // Arbitrary identity value
	parameter logic [7:0] FEATURES = 8'h53, // Arbitrary identity value
	parameter logic [7:0] FW_REVISION = 8'h33,
	parameter logic [7:0] FW_VERSION = 8'h31
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic mbox_slot_cleared,
	input wire logic sel_start,
	input wire logic scsi_bsy,
	output logic sel_timeout,
	output logic probe_req,
	output logic [2:0] probe_target,
	output logic [2:0] probe_lun,
	input wire logic probe_done,
	input wire logic probe_present,
	input wire logic xfer_want,
	input wire logic xfer_done,
	input wire logic bm_ack,
	output logic bm_request,
	output logic bm_owned
);

	typedef enum logic [2:0] {S_IDLE, S_PARAM, S_EXEC, S_REPLY, S_PROBE} ash_state_t;

	ash_state_t state;
	ash_flags_t flg;
	ash_cfg_t cfg;
	logic [7:0] cmd_byte;
	logic [7:0] opcode;
	logic [7:0] prm [4];
	logic [2:0] prm_cnt;
	logic [7:0] rbuf [8];
	logic [3:0] rlen;
	logic [3:0] ridx;
	logic [7:0] data_in;
	logic slot_en;
	logic sel_en;
	logic [15:0] sel_ms;
	logic [3:0] preempt_us;
	logic ex_done;
	logic ex_rej;
	logic rfin;
	logic load;
	logic own;
	logic [31:0] rd_cfg;
	logic [31:0] rd_set;
	logic [10:0] hold_cyc;
	logic [10:0] pre_cnt;
	logic sel_act;
	logic [31:0] sel_cyc;
	logic [15:0] sel_msc;

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	// Read data is sampled in the setup phase, so every access has no wait
	wire acc = psel & penable;
	wire wr = acc & pwrite;
	wire mapped = paddr inside {ADDR_CMD, ADDR_STATUS, ADDR_DATA_IN, ADDR_CONFIG, ADDR_SETTINGS};
	wire cmd_wr = wr && paddr == ADDR_CMD && !flg.port_full && (state == S_IDLE || state == S_PARAM);
	wire stat_wr = wr && paddr == ADDR_STATUS;
	wire din_rd = acc && !pwrite && paddr == ADDR_DATA_IN;
	wire din_setup = psel && !penable && !pwrite && paddr == ADDR_DATA_IN;
	wire busy = state != S_IDLE;

	assign pready = 1'b1;
	assign pslverr = acc & ~mapped;

	always_comb begin
		rd_cfg = '0;
		rd_cfg[CFG_DMA_LSB +: 2] = cfg.dma;
		rd_cfg[CFG_IRQ_LSB +: 8] = cfg.irq;
		rd_cfg[CFG_ID_LSB +: 3] = cfg.scsi_id;
		rd_set = '0;
		rd_set[SET_MS_LSB +: 16] = sel_ms;
		rd_set[SET_SELEN_BIT] = sel_en;
		rd_set[SET_SLOTEN_BIT] = slot_en;
		rd_set[SET_PRE_LSB +: 4] = preempt_us;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (psel && !penable) begin
			case (paddr)
				ADDR_CMD, ADDR_STATUS: prdata <= {26'h0, busy, flg};
				ADDR_DATA_IN: prdata <= {24'h0, data_in};
				ADDR_CONFIG: prdata <= rd_cfg;
				ADDR_SETTINGS: prdata <= rd_set;
				default: prdata <= '0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg <= {CFG_ID_DEF, CFG_IRQ_DEF, CFG_DMA_DEF};
		end else if (wr && paddr == ADDR_CONFIG) begin
			cfg <= {pwdata[CFG_ID_LSB +: 3], pwdata[CFG_IRQ_LSB +: 8], pwdata[CFG_DMA_LSB +: 2]};
		end
	end

	// ----------------------------------------------------------------
	// Command execution decode
	// ----------------------------------------------------------------
	always_comb begin
		ex_done = 1'b0;
		ex_rej = 1'b0;
		if (state == S_EXEC) begin
			case (opcode)
				OP_TEST, OP_OFF_BUS, OP_XFER_RATE: ex_done = 1'b1;
				OP_BOARD_ID, OP_CONFIG, OP_DEVICES: ex_done = 1'b0;
				OP_SLOT_EN: begin
					// Valid enable stays silent to spare the host an interrupt
					ex_done = prm[0] > FLAG_ON;
					ex_rej = prm[0] > FLAG_ON;
				end
				OP_SEL_TO: begin
					ex_done = 1'b1;
					ex_rej = prm[0] > FLAG_ON || prm[1] != 8'h00;
				end
				OP_PREEMPT: begin
					ex_done = 1'b1;
					ex_rej = prm[0] > PREEMPT_MAX_US;
				end
				default: begin
					ex_done = 1'b1;
					ex_rej = 1'b1;
				end
			endcase
		end
	end

	assign load = state == S_REPLY && !flg.waiting && ridx != rlen && !din_setup;
	assign rfin = state == S_REPLY && ridx == rlen && !flg.waiting;
	assign own = probe_target == cfg.scsi_id;
	assign probe_req = state == S_PROBE && !own;

	// ----------------------------------------------------------------
	// Status flags, set wins over clear
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flg <= '0;
		end else begin
			flg.done <= ex_done | rfin | (flg.done & ~(stat_wr & pwdata[ST_DONE_BIT]));
			flg.rejected <= ex_rej | (flg.rejected & ~(stat_wr & pwdata[ST_REJ_BIT]));
			flg.slot_free <= (mbox_slot_cleared & slot_en) |
				(flg.slot_free & ~(stat_wr & pwdata[ST_SLOT_BIT]));
			// Port clears one cycle after a byte lands: the gate the host polls
			flg.port_full <= cmd_wr | (flg.port_full & state != S_IDLE & state != S_PARAM);
			flg.waiting <= load | (flg.waiting & ~din_rd);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_byte <= '0;
			data_in <= '0;
		end else begin
			if (cmd_wr) begin
				cmd_byte <= pwdata[7:0];
			end
			if (load) begin
				data_in <= rbuf[ridx[2:0]];
			end
		end
	end

	// ----------------------------------------------------------------
	// Command sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= S_IDLE;
			opcode <= '0;
			prm_cnt <= '0;
			rlen <= '0;
			ridx <= '0;
			probe_target <= '0;
			probe_lun <= '0;
			for (int i = 0; i < 4; i++) begin
				prm[i] <= '0;
			end
			for (int i = 0; i < 8; i++) begin
				rbuf[i] <= '0;
			end
		end else begin
			case (state)
				S_IDLE: begin
					if (flg.port_full) begin
						opcode <= cmd_byte;
						prm_cnt <= '0;
						state <= f_param_count(cmd_byte) == 3'h0 ? S_EXEC : S_PARAM;
					end
				end
				S_PARAM: begin
					if (flg.port_full) begin
						prm[prm_cnt[1:0]] <= cmd_byte;
						prm_cnt <= prm_cnt + 3'h1;
						if (prm_cnt + 3'h1 == f_param_count(opcode)) begin
							state <= S_EXEC;
						end
					end
				end
				S_EXEC: begin
					ridx <= '0;
					case (opcode)
						OP_BOARD_ID: begin
							rbuf[0] <= BOARD_TYPE;
							rbuf[1] <= FEATURES;
							rbuf[2] <= FW_REVISION;
							rbuf[3] <= FW_VERSION;
							rlen <= ID_LEN;
							state <= S_REPLY;
						end
						OP_CONFIG: begin
							rbuf[0] <= f_dma_code(cfg.dma);
							rbuf[1] <= cfg.irq;
							rbuf[2] <= {5'h00, cfg.scsi_id};
							rlen <= CFG_LEN;
							state <= S_REPLY;
						end
						OP_DEVICES: begin
							// Cleared up front, so the own-ID byte stays zero
							for (int i = 0; i < 8; i++) begin
								rbuf[i] <= '0;
							end
							probe_target <= '0;
							probe_lun <= '0;
							state <= S_PROBE;
						end
						default: state <= S_IDLE;
					endcase
				end
				S_REPLY: begin
					if (load) begin
						ridx <= ridx + 4'h1;
					end
					if (rfin) begin
						state <= S_IDLE;
					end
				end
				S_PROBE: begin
					if (own || probe_done) begin
						if (!own) begin
							rbuf[probe_target][probe_lun] <= probe_present;
						end
						if (own || probe_lun == 3'h7) begin
							probe_lun <= '0;
							probe_target <= probe_target + 3'h1;
							if (probe_target == 3'h7) begin
								rlen <= DEV_LEN;
								state <= S_REPLY;
							end
						end else begin
							probe_lun <= probe_lun + 3'h1;
						end
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Settings applied by valid commands
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slot_en <= 1'b0;
			sel_en <= 1'b1;
			sel_ms <= SEL_TO_DEF_MS;
			preempt_us <= PREEMPT_DEF_US;
		end else if (state == S_EXEC && !ex_rej) begin
			if (opcode == OP_SLOT_EN) begin
				slot_en <= prm[0][0];
			end
			if (opcode == OP_SEL_TO) begin
				sel_en <= prm[0][0];
				sel_ms <= {prm[2], prm[3]};
			end
			if (opcode == OP_PREEMPT) begin
				preempt_us <= prm[0][3:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Selection time-out
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_act <= 1'b0;
			sel_cyc <= '0;
			sel_msc <= '0;
			sel_timeout <= 1'b0;
		end else begin
			sel_timeout <= 1'b0;
			if (sel_start && sel_en) begin
				sel_act <= 1'b1;
				sel_cyc <= '0;
				sel_msc <= '0;
			end else if (sel_act) begin
				if (scsi_bsy) begin
					sel_act <= 1'b0;
				end else if (sel_msc == sel_ms) begin
					sel_act <= 1'b0;
					sel_timeout <= 1'b1;
				end else if (sel_cyc == 32'(CYC_PER_MS - 1)) begin
					sel_cyc <= '0;
					sel_msc <= sel_msc + 16'h1;
				end else begin
					sel_cyc <= sel_cyc + 32'h1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Bus master request and preempt release
	// ----------------------------------------------------------------
	assign hold_cyc = 11'(32'(preempt_us) * CYC_PER_US);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bm_request <= 1'b0;
			bm_owned <= 1'b0;
			pre_cnt <= '0;
		end else if (!bm_request) begin
			bm_request <= xfer_want;
			pre_cnt <= '0;
		end else if (!bm_owned) begin
			bm_owned <= bm_ack;
		end else if (xfer_done || (!bm_ack && pre_cnt + 11'h1 >= hold_cyc)) begin
			bm_request <= 1'b0;
			bm_owned <= 1'b0;
		end else if (!bm_ack) begin
			pre_cnt <= pre_cnt + 11'h1;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic up;
	logic [11:0] lost_cnt;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			up <= 1'b0;
			lost_cnt <= '0;
		end else begin
			up <= 1'b1;
			lost_cnt <= bm_owned && !bm_ack ? lost_cnt + 12'h1 : 12'h0;
		end
	end

	property p_id_reply;
		state == S_EXEC && opcode == OP_BOARD_ID |=> rlen == ID_LEN && rbuf[2] == FW_REVISION;
	endproperty
	a_id_reply: assert property (p_id_reply) else $error("id reply wrong");

	property p_done_after_reply;
		rfin |=> flg.done && state == S_IDLE;
	endproperty
	a_done_after_reply: assert property (p_done_after_reply) else $error("no done");

	property p_slot_quiet;
		state == S_EXEC && opcode == OP_SLOT_EN && prm[0] <= FLAG_ON && !stat_wr
			|=> flg.done == $past(flg.done) && slot_en == $past(prm[0][0]);
	endproperty
	a_slot_quiet: assert property (p_slot_quiet) else $error("slot enable wrong");

	property p_slot_bad;
		state == S_EXEC && opcode == OP_SLOT_EN && prm[0] > FLAG_ON
			|=> flg.done && flg.rejected;
	endproperty
	a_slot_bad: assert property (p_slot_bad) else $error("bad slot value");

	property p_sel_reject;
		state == S_EXEC && opcode == OP_SEL_TO && prm[1] != 8'h00 |=> flg.rejected && flg.done;
	endproperty
	a_sel_reject: assert property (p_sel_reject) else $error("sel reject");

	property p_sel_fire;
		sel_act && sel_msc == sel_ms && !scsi_bsy && !(sel_start && sel_en)
			|=> sel_timeout ##1 !sel_timeout;
	endproperty
	a_sel_fire: assert property (p_sel_fire) else $error("no timeout");

	property p_sel_default;
		!up |-> sel_ms == SEL_TO_DEF_MS;
	endproperty
	a_sel_default: assert property (p_sel_default) else $error("ms");

	property p_pre_store;
		state == S_EXEC && opcode == OP_PREEMPT |=>
			flg.rejected == ($past(prm[0]) > PREEMPT_MAX_US || $past(flg.rejected)) ||
			$past(stat_wr);
	endproperty
	a_pre_store: assert property (p_pre_store) else $error("preempt check");

	property p_grant;
		$rose(bm_owned) |-> $past(bm_ack) && $past(bm_request);
	endproperty
	a_grant: assert property (p_grant) else $error("owned without ack");

	property p_release;
		lost_cnt <= {1'b0, hold_cyc};
	endproperty
	a_release: assert property (p_release) else $error("hold exceeded");

	property p_waiting_clear;
		din_rd && flg.waiting |=> !flg.waiting;
	endproperty
	a_waiting_clear: assert property (p_waiting_clear) else $error("waiting held");

	c_id: cover property (rfin && opcode == OP_BOARD_ID);
	c_probe: cover property (rfin && opcode == OP_DEVICES);
	c_timeout: cover property (sel_timeout);
	c_preempt: cover property ($fell(bm_owned) && !bm_ack && !xfer_done);

endmodule : ash_handler

// *** ash_pkg.sv ***
// Constants, types and decode helpers of the adapter setup command handler
package ash_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CMD = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_DATA_IN = 8'h08;
	localparam logic [7:0] ADDR_CONFIG = 8'h0C;
	localparam logic [7:0] ADDR_SETTINGS = 8'h10;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int ST_DONE_BIT = 0;
	localparam int ST_REJ_BIT = 1;
	localparam int ST_SLOT_BIT = 4;
	localparam int CFG_DMA_LSB = 0;
	localparam int CFG_IRQ_LSB = 8;
	localparam int CFG_ID_LSB = 16;
	localparam int SET_MS_LSB = 0;
	localparam int SET_SELEN_BIT = 16;
	localparam int SET_SLOTEN_BIT = 20;
	localparam int SET_PRE_LSB = 24;

	// ----------------------------------------------------------------
	// Command codes and reply lengths
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_TEST = 8'h00;
	localparam logic [7:0] OP_BOARD_ID = 8'h04;
	localparam logic [7:0] OP_SLOT_EN = 8'h05;
	localparam logic [7:0] OP_SEL_TO = 8'h06;
	localparam logic [7:0] OP_PREEMPT = 8'h07;
	localparam logic [7:0] OP_OFF_BUS = 8'h08;
	localparam logic [7:0] OP_XFER_RATE = 8'h09;
	localparam logic [7:0] OP_DEVICES = 8'h0A;
	localparam logic [7:0] OP_CONFIG = 8'h0B;
	localparam logic [3:0] ID_LEN = 4'h4;
	localparam logic [3:0] CFG_LEN = 4'h3;
	localparam logic [3:0] DEV_LEN = 4'h8;
	localparam logic [7:0] FLAG_ON = 8'h01;

	// ----------------------------------------------------------------
	// Reset values and timing
	// ----------------------------------------------------------------
	localparam logic [1:0] CFG_DMA_DEF = 2'h0;
	localparam logic [7:0] CFG_IRQ_DEF = 8'h04;
	localparam logic [2:0] CFG_ID_DEF = 3'h7;
	localparam logic [15:0] SEL_TO_DEF_MS = 16'h00FA;
	localparam logic [3:0] PREEMPT_DEF_US = 4'h7;
	localparam logic [7:0] PREEMPT_MAX_US = 8'h0F;
	localparam int CLK_PERIOD_NS = 10;
	localparam int US_NS = 1000;
	localparam int MS_NS = 1000000;
	localparam int CYC_PER_US = US_NS / CLK_PERIOD_NS;

	typedef struct packed {
		logic slot_free;
		logic waiting;
		logic port_full;
		logic rejected;
		logic done;
	} ash_flags_t;

	typedef struct packed {
		logic [2:0] scsi_id;
		logic [7:0] irq;
		logic [1:0] dma;
	} ash_cfg_t;

	function automatic logic [2:0] f_param_count(input logic [7:0] op);
		case (op)
			OP_SLOT_EN, OP_PREEMPT, OP_OFF_BUS, OP_XFER_RATE: f_param_count = 3'h1;
			OP_SEL_TO: f_param_count = 3'h4;
			default: f_param_count = 3'h0;
		endcase
	endfunction : f_param_count

	// Option 0 reports no channel, 1..3 report channels 5..7
	function automatic logic [7:0] f_dma_code(input logic [1:0] sel);
		case (sel)
			2'h1: f_dma_code = 8'h20;
			2'h2: f_dma_code = 8'h40;
			2'h3: f_dma_code = 8'h80;
			default: f_dma_code = 8'h00;
		endcase
	endfunction : f_dma_code

endpackage : ash_pkg

// *** ash_partner.sv ***
// Far-side model: unit probe responder and system bus arbiter
`timescale 1ns/1ps
module ash_partner (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic slow,
	input wire logic preempt,
	input wire logic probe_req,
	input wire logic [2:0] probe_target,
	input wire logic [2:0] probe_lun,
	output logic probe_done,
	output logic probe_present,
	input wire logic bm_request,
	output logic bm_ack
);
	logic pend;
	logic cool;
	logic [2:0] cnt;

	// ----------------------------------------------------------------
	// Unit probe
	// ----------------------------------------------------------------
	// Present only where lun equals target xor 5; line toggles when not valid
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend <= 1'b0;
			cool <= 1'b0;
			cnt <= 3'h0;
			probe_done <= 1'b0;
			probe_present <= 1'b0;
		end else begin
			probe_done <= 1'b0;
			probe_present <= ~probe_present;
			if (cool) begin
				cool <= 1'b0;
			end else if (pend && cnt == 3'h0) begin
				probe_done <= 1'b1;
				probe_present <= (probe_target ^ probe_lun) == 3'h5;
				pend <= 1'b0;
				cool <= 1'b1;
			end else if (pend) begin
				cnt <= cnt - 3'h1;
			end else if (probe_req) begin
				pend <= 1'b1;
				cnt <= slow ? 3'h4 : 3'h0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Arbiter
	// ----------------------------------------------------------------
	// Grant follows request unless a preempt is staged
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bm_ack <= 1'b0;
		end else begin
			bm_ack <= bm_request & ~preempt;
		end
	end
endmodule : ash_partner

// *** tb_top.sv ***
// Self-checking bench of the adapter setup command handler
`timescale 1ns/1ps
module tb_top;
	import ash_pkg::*;
	localparam int CPM = 20;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rv;
	logic pready, pslverr, ev, sel_timeout, probe_req, probe_done, probe_present;
	logic [2:0] probe_target, probe_lun;
	logic mbox_slot_cleared = 1'b0, sel_start = 1'b0, scsi_bsy = 1'b0;
	logic xfer_want = 1'b0, xfer_done = 1'b0, bm_ack, bm_request, bm_owned;
	logic slow = 1'b0, preempt = 1'b0;
	logic [7:0] id_b [4] = '{8'h6C, 8'h2E, 8'h35, 8'h32};
	int n_fail = 0, num_checks = 0, n_to = 0, cyc = 0, to_cyc = 0;

	// Arbitrary identity values
	ash_handler #(.CYC_PER_MS(CPM), .BOARD_TYPE(8'h6C), .FEATURES(8'h2E), .FW_REVISION(8'h35),
		.FW_VERSION(8'h32)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .mbox_slot_cleared, .sel_start, .scsi_bsy, .sel_timeout,
		.probe_req, .probe_target, .probe_lun, .probe_done, .probe_present, .xfer_want,
		.xfer_done, .bm_ack, .bm_request, .bm_owned);
	ash_partner u_part (.pclk, .presetn, .slow, .preempt, .probe_req, .probe_target,
		.probe_lun, .probe_done, .probe_present, .bm_request, .bm_ack);

	always #5 pclk = ~pclk;
	always @(posedge pclk) begin
		// Non-blocking, so a task that reads cyc at this edge never races the count
		cyc <= cyc + 1;
		if (sel_timeout === 1'b1) begin
			n_to++;
			to_cyc = cyc;
		end
	end

	// ----------------------------------------------------------------
	// Checking and bus tasks
	// ----------------------------------------------------------------
	task automatic stop_test();
		$display("checks %0d, mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", s, e, g);
		end
	endtask : chk
	task automatic fail(input string s);
		n_fail++;
		$display("unexpected %s: expected 1, seen 0", s);
		stop_test();
	endtask : fail
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) fail("pready");
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic fld(input string s, input logic [7:0] a, input int l, input logic [31:0] m,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(s, e, (rv >> l) & m);
	endtask : fld
	task automatic poll(input int b, input logic v);
		int n;
		n = 0;
		do begin
			apb(1'b0, ADDR_STATUS, 32'h0);
			n++;
		end while (rv[b] !== v && n < 1000);
		if (rv[b] !== v) fail("status wait");
	endtask : poll
	task automatic send(input logic [7:0] b);
		poll(2, 1'b0);
		apb(1'b1, ADDR_CMD, {24'h0, b});
		repeat (3) @(posedge pclk);
	endtask : send
	task automatic done_chk(input logic rej);
		poll(0, 1'b1);
		chk("rejected", {31'h0, rej}, {31'h0, rv[1]});
		apb(1'b1, ADDR_STATUS, 32'h13);
	endtask : done_chk
	task automatic reply(input logic [7:0] e);
		poll(3, 1'b1);
		apb(1'b0, ADDR_DATA_IN, 32'h0);
		chk("reply byte", {24'h0, e}, rv);
	endtask : reply
	task automatic sel_try(input logic bsy, input int ms, output int dt, output int nt);
		int t0;
		nt = n_to;
		@(posedge pclk);
		sel_start <= 1'b1;
		t0 = cyc;
		@(posedge pclk);
		sel_start <= 1'b0;
		scsi_bsy <= bsy;
		repeat (ms * CPM + 40) @(posedge pclk);
		scsi_bsy <= 1'b0;
		dt = to_cyc - t0;
		nt = n_to - nt;
	endtask : sel_try
	task automatic wait_own(input logic v, output int t);
		t = 0;
		while (bm_owned !== v && t < 1000) begin
			@(posedge pclk);
			t++;
		end
		if (bm_owned !== v) fail("bus ownership");
	endtask : wait_own
	function automatic logic [7:0] exp_dev(input int t, input logic [2:0] own_id);
		// Partner reports a unit only where lun equals target xor 5
		exp_dev = 3'(t) == own_id ? 8'h00 : 8'h01 << (t ^ 5);
	endfunction : exp_dev
	function automatic logic [7:0] exp_dma(input int opt);
		// Option 0 is no channel, options 1 to 3 are channels 5 to 7
		exp_dma = opt == 0 ? 8'h00 : 8'h10 << opt;
	endfunction : exp_dma

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		int c, dt, nt, ms, exp_ms, exp_pre;
		logic [7:0] v, irq;
		logic [2:0] id;
		logic [31:0] s0;
		logic [7:0] pv [4];
		pv = '{8'h0F, 8'h10, 8'h00, 8'h02};
		v = 8'($urandom(32'h3da87b08));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		fld("settings", ADDR_SETTINGS, 0, 32'hFFFFFFFF, 32'h070100FA);
		fld("config", ADDR_CONFIG, 0, 32'hFFFFFFFF, 32'h00070400);
		apb(1'b0, 8'h14, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, ev});
		$display("test reset done");
		send(OP_BOARD_ID);
		for (c = 0; c < 4; c++) begin
			if (c == 3) fld("early done", ADDR_STATUS, 0, 32'h1, 32'h0);
			reply(id_b[c]);
		end
		done_chk(1'b0);
		$display("test board id done");
		for (c = 1; c >= 0; c--) begin
			send(OP_SLOT_EN);
			send(8'(c));
			repeat (10) @(posedge pclk);
			fld("quiet done", ADDR_STATUS, 0, 32'h1, 32'h0);
			@(posedge pclk);
			mbox_slot_cleared <= 1'b1;
			@(posedge pclk);
			mbox_slot_cleared <= 1'b0;
			fld("slot free", ADDR_STATUS, ST_SLOT_BIT, 32'h1, 32'(c));
			apb(1'b1, ADDR_STATUS, 32'h13);
		end
		send(OP_SLOT_EN);
		send(8'h02 + 8'($urandom_range(253)));
		done_chk(1'b1);
		$display("test slot enable done");
		exp_ms = 250;
		for (c = 0; c < 3; c++) begin
			ms = 256 + $urandom_range(3);
			send(OP_SEL_TO);
			send(c == 1 ? 8'h02 : 8'h01);
			send(c == 2 ? 8'h01 : 8'h00);
			send(8'(ms >> 8));
			fld("early verdict", ADDR_STATUS, 0, 32'h3, 32'h0);
			send(8'(ms));
			done_chk(c != 0);
			if (c == 0) exp_ms = ms;
			fld("timeout ms", ADDR_SETTINGS, SET_MS_LSB, 32'hFFFF, 32'(exp_ms));
		end
		sel_try(1'b0, exp_ms, dt, nt);
		chk("timeout pulses", 32'h1, 32'(nt));
		chk("timeout delay", 32'h1, 32'(dt >= exp_ms * CPM && dt <= exp_ms * CPM + 3));
		sel_try(1'b1, exp_ms, dt, nt);
		chk("timeout with busy", 32'h0, 32'(nt));
		send(OP_SEL_TO);
		for (c = 0; c < 4; c++) send(c == 3 ? 8'h01 : 8'h00);
		done_chk(1'b0);
		sel_try(1'b0, 1, dt, nt);
		chk("timeout disabled", 32'h0, 32'(nt));
		$display("test selection timeout done");
		exp_pre = 7;
		for (c = 0; c < 4; c++) begin
			v = (c == 2) ? 8'h10 + 8'($urandom_range(239)) : pv[c];
			send(OP_PREEMPT);
			send(v);
			done_chk(v > 8'h0F);
			if (v <= 8'h0F) exp_pre = v;
			fld("preempt us", ADDR_SETTINGS, SET_PRE_LSB, 32'hF, 32'(exp_pre));
		end
		apb(1'b0, ADDR_SETTINGS, 32'h0);
		s0 = rv;
		for (c = 0; c < 2; c++) begin
			send(c == 0 ? OP_OFF_BUS : OP_XFER_RATE);
			send(8'($urandom));
			done_chk(1'b0);
			fld("settings kept", ADDR_SETTINGS, 0, 32'hFFFFFFFF, s0);
		end
		$display("test preempt and no-op done");
		for (c = 0; c < 4; c++) begin
			id = 3'($urandom);
			irq = 8'($urandom);
			apb(1'b1, ADDR_CONFIG, {13'h0, id, irq, 6'h0, 2'(c)});
			send(OP_CONFIG);
			reply(exp_dma(c));
			reply(irq);
			reply({5'h0, id});
			done_chk(1'b0);
		end
		slow <= 1'b1;
		send(OP_DEVICES);
		for (c = 0; c < 8; c++) reply(exp_dev(c, id));
		done_chk(1'b0);
		slow <= 1'b0;
		$display("test inquiries done");
		@(posedge pclk);
		xfer_want <= 1'b1;
		wait_own(1'b1, dt);
		chk("grant before ownership", 32'h1, {31'h0, bm_ack});
		@(posedge pclk);
		preempt <= 1'b1;
		wait_own(1'b0, dt);
		chk("preempt release", 32'h1, 32'(dt <= exp_pre * 100 + 3));
		preempt <= 1'b0;
		wait_own(1'b1, dt);
		xfer_want <= 1'b0;
		xfer_done <= 1'b1;
		@(posedge pclk);
		xfer_done <= 1'b0;
		wait_own(1'b0, dt);
		chk("done release", 32'h1, 32'(dt <= 3));
		$display("test bus master done");
		stop_test();
	end
endmodule : tb_top
